// ==== hw/aih_pkg.sv ====
// Constants and types shared by the two-wire sensor host controller
package aih_pkg;

    // Timing: quarter of a 400 kHz bit, rounded up to whole cycles
    localparam int CLK_MHZ = 125;
    localparam int T_QUARTER_NS = 625;
    localparam int QUARTER_CYC = (T_QUARTER_NS * CLK_MHZ + 999) / 1000;

    localparam int COUNT_W = 8;

    // Fixed upper six bits of the target bus address
    localparam logic [5:0] TARGET_ADDR_HI = 6'h0c;
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ = 1'b1;

    // Host register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_COUNT = 8'h01;
    localparam logic [7:0] REG_INDEX = 8'h02;
    localparam logic [7:0] REG_TXDATA = 8'h03;
    localparam logic [7:0] REG_RXDATA = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h05;

    // Control register fields
    localparam int CTRL_GO = 0;
    localparam int CTRL_READ = 1;
    localparam int CTRL_AUTOINC = 2;
    localparam int CTRL_ADDR_LSB = 3;

    // Status register fields
    localparam int STAT_BUSY = 0;
    localparam int STAT_TX_FULL = 1;
    localparam int STAT_RX_VALID = 2;
    localparam int STAT_NACK = 3;
    localparam int STAT_DONE = 4;

    localparam int INDEX_AUTOINC = 7;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [1:0] Q_LAST = 2'h3;
    localparam logic [1:0] Q_HIGH = 2'h2;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_START = 3'b001,
        S_BYTE = 3'b010,
        S_WAIT = 3'b011,
        S_RSTART = 3'b100,
        S_STOP = 3'b101
    } aih_state_e;

    typedef enum logic [2:0] {
        ST_ADDR_W = 3'b000,
        ST_INDEX = 3'b001,
        ST_WDATA = 3'b010,
        ST_ADDR_R = 3'b011,
        ST_RDATA = 3'b100
    } aih_stage_e;

endpackage

// ==== hw/aih_sync.sv ====
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module aih_sync #(
    parameter int W = 2
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    logic [W-1:0] meta;

    // Lines idle high, so reset to released
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meta <= '1;
            dout <= '1;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end

endmodule

// ==== hw/aih_i2c_host.sv ====
// Two-wire bus controller that reads and writes the sensor's registers
`timescale 1ns/10ps
module aih_i2c_host #(
    parameter int QUARTER = aih_pkg::QUARTER_CYC,
    parameter int CNT_W = aih_pkg::COUNT_W
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic mode_sel_pin,
    output logic addr_lsb_select_pin
);

    localparam int QW = $clog2(QUARTER + 1);
    localparam logic [QW-1:0] Q_END = QW'(QUARTER - 1);
    localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

    function automatic logic [7:0] target_byte(input logic lsb,
                                               input logic dir);
        target_byte = {aih_pkg::TARGET_ADDR_HI, lsb, dir};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and open-drain drive

    logic scl_s;
    logic sda_s;
    logic scl_low;
    logic sda_low;

    aih_sync #(.W(2)) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .din({scl_in, sda_in}),
        .dout({scl_s, sda_s})
    );

    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe = scl_low;
    assign sda_oe = sda_low;
    assign mode_sel_pin = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // Host registers

    logic cfg_read;
    logic cfg_autoinc;
    logic cfg_addr_lsb;
    logic [CNT_W-1:0] cfg_count;
    logic [6:0] cfg_index;
    logic [7:0] txd;
    logic tx_full;
    logic [7:0] rxd;
    logic rx_valid;
    logic st_done;
    logic st_nack;

    aih_pkg::aih_state_e state;
    aih_pkg::aih_stage_e stage;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [CNT_W-1:0] remain;
    logic [QW-1:0] qcnt;

    logic busy;
    logic go;
    logic active;
    logic stall;
    logic tick;
    logic tx_stage;
    logic byte_end;
    logic rx_store;
    logic take_tx;
    logic take_rx;
    logic nack_ev;
    logic finish;
    logic wr_ctrl;

    assign busy = state != aih_pkg::S_IDLE;
    assign wr_ctrl = reg_wr && reg_addr == aih_pkg::REG_CTRL;
    assign go = wr_ctrl && reg_wdata[aih_pkg::CTRL_GO] && !busy;
    assign addr_lsb_select_pin = cfg_addr_lsb;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cfg_read <= 1'b0;
            cfg_autoinc <= 1'b0;
            cfg_addr_lsb <= 1'b0;
        end else if (wr_ctrl && !busy) begin
            cfg_read <= reg_wdata[aih_pkg::CTRL_READ];
            cfg_autoinc <= reg_wdata[aih_pkg::CTRL_AUTOINC];
            cfg_addr_lsb <= reg_wdata[aih_pkg::CTRL_ADDR_LSB];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cfg_count <= ONE;
            cfg_index <= 7'h00;
        end else if (reg_wr && !busy) begin
            if (reg_addr == aih_pkg::REG_COUNT) begin
                cfg_count <= CNT_W'(reg_wdata);
            end
            if (reg_addr == aih_pkg::REG_INDEX) begin
                cfg_index <= reg_wdata[6:0];
            end
        end
    end

    // Flags: a hardware set wins over a same-cycle clear
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            txd <= 8'h00;
            tx_full <= 1'b0;
            rx_valid <= 1'b0;
            rxd <= 8'h00;
            st_done <= 1'b0;
            st_nack <= 1'b0;
        end else begin
            if (take_tx) begin
                tx_full <= 1'b0;
            end
            if (reg_wr && reg_addr == aih_pkg::REG_TXDATA) begin
                txd <= reg_wdata;
                tx_full <= 1'b1;
            end
            if (reg_rd && reg_addr == aih_pkg::REG_RXDATA) begin
                rx_valid <= 1'b0;
            end
            if (rx_store) begin
                rxd <= sh;
                rx_valid <= 1'b1;
            end
            if (reg_wr && reg_addr == aih_pkg::REG_STATUS) begin
                if (reg_wdata[aih_pkg::STAT_DONE]) begin
                    st_done <= 1'b0;
                end
                if (reg_wdata[aih_pkg::STAT_NACK]) begin
                    st_nack <= 1'b0;
                end
            end
            if (go) begin
                st_done <= 1'b0;
                st_nack <= 1'b0;
            end
            if (finish) begin
                st_done <= 1'b1;
            end
            if (nack_ev) begin
                st_nack <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                aih_pkg::REG_CTRL: reg_rdata <= {4'h0, cfg_addr_lsb,
                                                 cfg_autoinc, cfg_read, 1'b0};
                aih_pkg::REG_COUNT: reg_rdata <= 8'(cfg_count);
                aih_pkg::REG_INDEX: reg_rdata <= {1'b0, cfg_index};
                aih_pkg::REG_TXDATA: reg_rdata <= txd;
                aih_pkg::REG_RXDATA: reg_rdata <= rxd;
                aih_pkg::REG_STATUS: reg_rdata <= {3'h0, st_done, st_nack,
                                                   rx_valid, tx_full, busy};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Quarter-bit timing, held while the sensor stretches SCL

    assign active = busy && state != aih_pkg::S_WAIT;
    assign stall = q == aih_pkg::Q_HIGH && !scl_s;
    assign tick = active && !stall && qcnt == Q_END;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            qcnt <= '0;
        end else if (!active || stall || tick) begin
            qcnt <= '0;
        end else begin
            qcnt <= qcnt + QW'(1);
        end
    end

    assign tx_stage = stage != aih_pkg::ST_RDATA;
    assign byte_end = state == aih_pkg::S_BYTE && tick
                      && q == aih_pkg::Q_LAST && bitn == aih_pkg::ACK_BIT;
    assign rx_store = state == aih_pkg::S_BYTE && tick && q == 2'h0
                      && bitn == aih_pkg::ACK_BIT && !tx_stage;
    assign take_tx = state == aih_pkg::S_WAIT
                     && stage == aih_pkg::ST_WDATA && tx_full;
    assign take_rx = state == aih_pkg::S_WAIT
                     && stage == aih_pkg::ST_RDATA && !rx_valid;
    assign nack_ev = byte_end && tx_stage && sda_s;
    assign finish = state == aih_pkg::S_STOP && tick && q == aih_pkg::Q_LAST;

    ////////////////////////////////////////////////////////////////////////
    // Transfer sequencer

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state <= aih_pkg::S_IDLE;
            stage <= aih_pkg::ST_ADDR_W;
            q <= 2'h0;
            bitn <= 4'h0;
            sh <= 8'h00;
            remain <= ONE;
            scl_low <= 1'b0;
            sda_low <= 1'b0;
        end else begin
            if (tick) begin
                q <= q + 2'h1;
            end
            unique case (state)
                aih_pkg::S_IDLE: begin
                    scl_low <= 1'b0;
                    sda_low <= 1'b0;
                    q <= 2'h0;
                    bitn <= 4'h0;
                    if (go) begin
                        state <= aih_pkg::S_START;
                        stage <= aih_pkg::ST_ADDR_W;
                        sh <= target_byte(reg_wdata[aih_pkg::CTRL_ADDR_LSB],
                                          aih_pkg::DIR_WRITE);
                        remain <= (cfg_count == '0) ? ONE : cfg_count;
                    end
                end
                aih_pkg::S_START: begin
                    if (tick) begin
                        unique case (q)
                            2'h0: sda_low <= 1'b1;
                            2'h2: scl_low <= 1'b1;
                            2'h3: state <= aih_pkg::S_BYTE;
                            default: ;
                        endcase
                    end
                end
                aih_pkg::S_RSTART: begin
                    if (tick) begin
                        unique case (q)
                            2'h0: sda_low <= 1'b0;
                            2'h1: scl_low <= 1'b0;
                            2'h2: sda_low <= 1'b1;
                            2'h3: begin
                                scl_low <= 1'b1;
                                state <= aih_pkg::S_BYTE;
                            end
                        endcase
                    end
                end
                aih_pkg::S_STOP: begin
                    if (tick) begin
                        unique case (q)
                            2'h0: sda_low <= 1'b1;
                            2'h1: scl_low <= 1'b0;
                            2'h2: sda_low <= 1'b0;
                            2'h3: state <= aih_pkg::S_IDLE;
                        endcase
                    end
                end
                aih_pkg::S_WAIT: begin
                    q <= 2'h0;
                    bitn <= 4'h0;
                    if (take_tx) begin
                        sh <= txd;
                        state <= aih_pkg::S_BYTE;
                    end else if (take_rx) begin
                        state <= aih_pkg::S_BYTE;
                    end
                end
                aih_pkg::S_BYTE: begin
                    if (tick) begin
                        unique case (q)
                            2'h0: begin
                                if (bitn != aih_pkg::ACK_BIT) begin
                                    sda_low <= tx_stage && !sh[7];
                                end else begin
                                    sda_low <= !tx_stage
                                               && remain != ONE;
                                end
                            end
                            2'h1: scl_low <= 1'b0;
                            2'h2: ;
                            2'h3: begin
                                scl_low <= 1'b1;
                                if (bitn != aih_pkg::ACK_BIT) begin
                                    sh <= {sh[6:0], sda_s};
                                    bitn <= bitn + 4'h1;
                                end else begin
                                    bitn <= 4'h0;
                                    sda_low <= 1'b0;
                                end
                            end
                        endcase
                    end
                    if (byte_end) begin
                        unique case (stage)
                            aih_pkg::ST_ADDR_W: begin
                                if (sda_s) begin
                                    state <= aih_pkg::S_STOP;
                                end else begin
                                    stage <= aih_pkg::ST_INDEX;
                                    sh <= {cfg_autoinc || (cfg_read
                                           && remain != ONE),
                                           cfg_index};
                                end
                            end
                            aih_pkg::ST_INDEX: begin
                                if (sda_s) begin
                                    state <= aih_pkg::S_STOP;
                                end else if (cfg_read) begin
                                    state <= aih_pkg::S_RSTART;
                                    stage <= aih_pkg::ST_ADDR_R;
                                    sh <= target_byte(cfg_addr_lsb,
                                                      aih_pkg::DIR_READ);
                                end else begin
                                    state <= aih_pkg::S_WAIT;
                                    stage <= aih_pkg::ST_WDATA;
                                end
                            end
                            aih_pkg::ST_ADDR_R: begin
                                if (sda_s) begin
                                    state <= aih_pkg::S_STOP;
                                end else begin
                                    state <= aih_pkg::S_WAIT;
                                    stage <= aih_pkg::ST_RDATA;
                                end
                            end
                            aih_pkg::ST_WDATA,
                            aih_pkg::ST_RDATA: begin
                                if ((tx_stage && sda_s) || remain == ONE) begin
                                    state <= aih_pkg::S_STOP;
                                end else begin
                                    remain <= remain - ONE;
                                    state <= aih_pkg::S_WAIT;
                                end
                            end
                            default: state <= aih_pkg::S_STOP;
                        endcase
                    end
                end
                default: state <= aih_pkg::S_IDLE;
            endcase
        end
    end

endmodule

// ==== tb/aih_asserts.sv ====
// Pin and register-port checks for the two-wire host controller
`timescale 1ns/10ps
module aih_asserts #(
    parameter int QUARTER = 4
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic mode_sel_pin,
    input wire logic addr_lsb_select_pin
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic [7:0] hold_cnt;
    logic prev_oe;
    // Cycles since the clock enable last changed
    always_ff @(posedge clock) begin
        prev_oe <= scl_oe;
        if (!rst_n || scl_oe != prev_oe) begin
            hold_cnt <= 8'h00;
        end else if (hold_cnt != 8'hff) begin
            hold_cnt <= hold_cnt + 8'h01;
        end
    end
    ////////////////////////////////////////////////////////////
    sequence s_start;
        !scl_oe && $rose(sda_oe);
    endsequence
    sequence s_stop;
        !scl_oe && $fell(sda_oe);
    endsequence
    property p_mode_sel;
        mode_sel_pin;
    endproperty
    property p_open_drain;
        !scl_out && !sda_out;
    endproperty
    property p_start;
        s_start |-> scl_in ##[1:400] scl_oe;
    endproperty
    property p_stop;
        s_stop |-> scl_in ##1 (!scl_oe && !sda_oe) [*4];
    endproperty
    property p_stretch;
        !scl_oe && !scl_in |=> !scl_oe && $stable(sda_oe);
    endproperty
    property p_scl_phase;
        $changed(scl_oe) |-> hold_cnt >= QUARTER - 1;
    endproperty
    property p_lsb_pin;
        $changed(addr_lsb_select_pin) |->
            $past(reg_wr && reg_addr == aih_pkg::REG_CTRL) ||
            $past(reg_wr && reg_addr == aih_pkg::REG_CTRL, 2);
    endproperty
    property p_rdata_hold;
        !reg_rd |=> $stable(reg_rdata);
    endproperty
    property p_unmapped;
        reg_rd && reg_addr > 8'h05 |=> reg_rdata == 8'h00;
    endproperty
    a_mode_sel: assert property (p_mode_sel)
        else $error("chip select pin not high");
    a_open_drain: assert property (p_open_drain)
        else $error("pin drives high");
    a_start: assert property (p_start)
        else $error("bad start condition");
    a_stop: assert property (p_stop)
        else $error("bad stop condition");
    a_stretch: assert property (p_stretch)
        else $error("stretched clock not honoured");
    a_scl_phase: assert property (p_scl_phase)
        else $error("clock phase too short");
    a_lsb_pin: assert property (p_lsb_pin)
        else $error("select pin moved without control write");
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data changed without read");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
endmodule

bind aih_i2c_host aih_asserts #(.QUARTER(QUARTER)) u_asserts (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_in),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
    .sda_oe(sda_oe), .mode_sel_pin(mode_sel_pin),
    .addr_lsb_select_pin(addr_lsb_select_pin)
);

// ==== tb/aih_sensor_model.sv ====
// Behavioural two-wire sensor target with a 128-byte register file
`timescale 1ns/10ps
module aih_sensor_model (
    input wire logic clock,
    input wire logic scl,
    input wire logic sda,
    input wire logic cs_pin,
    input wire logic addr_lsb_select_pin,
    input wire logic nack_addr,
    input wire logic stretch,
    output logic scl_pull,
    output logic sda_pull
);
    logic [7:0] mem [0:127];
    logic [7:0] sh;
    logic [6:0] idx;
    logic ps = 1'b1;
    logic pd = 1'b1;
    logic inc, rd, tx, act;
    int bitn, byten, hold;
    initial begin
        for (int i = 0; i < 128; i++) mem[i] = i[7:0] ^ 8'ha5;
        act = 0;
        tx = 0;
        hold = 0;
        scl_pull = 0;
        sda_pull = 0;
    end
    ////////////////////////////////////////////////////////////
    always @(posedge clock) begin
        if (hold > 0) hold--;
        if (scl && ps && pd && !sda) begin
            act = cs_pin;
            tx = 0;
            bitn = 0;
            byten = 0;
            sda_pull <= 1'b0;
        end else if (scl && ps && !pd && sda) begin
            act = 0;
            sda_pull <= 1'b0;
        end else if (act && scl && !ps) begin
            if (bitn < 8 && !tx) sh = {sh[6:0], sda};
            else if (bitn == 8 && tx && sda) act = 0;
            bitn++;
        end else if (act && !scl && ps) begin
            if (bitn == 8) begin
                if (tx) begin
                    sda_pull <= 1'b0;
                end else if (byten > 0) begin
                    if (byten == 1) {inc, idx} = sh;
                    else mem[idx] = sh;
                    if (byten > 1) idx += 7'(inc);
                    sda_pull <= 1'b1;
                end else if (sh[7:1] == {6'b001100, addr_lsb_select_pin} &&
                             !nack_addr) begin
                    rd = sh[0];
                    sda_pull <= 1'b1;
                end else begin
                    act = 0;
                end
            end else if (bitn == 9) begin
                bitn = 0;
                byten++;
                tx = rd;
                if (stretch) hold = 20;
                if (tx) begin
                    sh = mem[idx];
                    idx += 7'(inc);
                end
                sda_pull <= tx && !sh[7];
            end else if (tx) begin
                sda_pull <= !sh[7 - bitn];
            end
        end
        scl_pull <= hold > 0;
        ps = scl;
        pd = sda;
    end
endmodule

// ==== tb/test_aih_i2c_host.sv ====
// Self-checking bench for the two-wire sensor host controller
`timescale 1ns/10ps
module test_aih_i2c_host;
    localparam int Q = 4;
    localparam bit [5:0] RK = 6'b101100;
    localparam bit [5:0] IK = 6'b100010;
    localparam bit [5:0] SK = 6'b001010;
    int nk [6] = '{1, 3, 1, 4, 2, 3};
    logic clock = 0;
    logic rst_n = 0;
    logic [7:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0;
    logic reg_wr = 0;
    logic reg_rd = 0;
    logic nack_addr = 0;
    logic stretch = 0;
    logic [7:0] reg_rdata;
    logic scl_oe, sda_oe, scl_out, sda_out, mode_sel_pin, lsb_pin;
    logic m_scl, m_sda;
    wire logic scl = ~(scl_oe | m_scl);
    wire logic sda = ~(sda_oe | m_sda);
    int errors = 0;
    int n_checks = 0;
    int idx;
    logic [31:0] seed = 32'h5573f1a2;
    logic [7:0] mem [0:127];

    aih_i2c_host #(.QUARTER(Q)) u_dut (
        .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .scl_in(scl), .scl_out(scl_out),
        .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .mode_sel_pin(mode_sel_pin),
        .addr_lsb_select_pin(lsb_pin)
    );
    aih_sensor_model u_sensor (
        .clock(clock), .scl(scl), .sda(sda), .cs_pin(mode_sel_pin),
        .addr_lsb_select_pin(lsb_pin), .nack_addr(nack_addr),
        .stretch(stretch), .scl_pull(m_scl), .sda_pull(m_sda)
    );
    ////////////////////////////////////////////////////////////
    function automatic logic [7:0] lfsr();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 0;
        #1 d = reg_rdata;
    endtask
    task automatic wait_st(input int b, input logic v);
        logic [7:0] s;
        int i;
        for (i = 0; i < 3000; i++) begin
            rd(aih_pkg::REG_STATUS, s);
            if (s[b] === v) break;
        end
        if (i == 3000) begin
            errors++;
            $display("[ERR] %0t status wait expired", $time);
        end
    endtask
    task automatic run(input bit r, input bit inc, input bit lsb,
                       input int n);
        logic [7:0] d;
        int j, p, step;
        step = (inc || (r && n > 1)) ? 1 : 0;
        wr(aih_pkg::REG_COUNT, n[7:0]);
        wr(aih_pkg::REG_INDEX, idx[7:0]);
        wr(aih_pkg::REG_CTRL, {4'h0, lsb, inc, r, 1'b1});
        for (j = 0; j < n; j++) begin
            p = (idx + j * step) % 128;
            if (r) begin
                wait_st(aih_pkg::STAT_RX_VALID, 1'b1);
                rd(aih_pkg::REG_RXDATA, d);
                check(d, mem[p]);
            end else begin
                d = lfsr();
                wait_st(aih_pkg::STAT_TX_FULL, 1'b0);
                wr(aih_pkg::REG_TXDATA, d);
                mem[p] = d;
            end
        end
        wait_st(aih_pkg::STAT_DONE, 1'b1);
        rd(aih_pkg::REG_STATUS, d);
        check(d, 8'h10);
        check(lsb_pin, lsb);
        rd(aih_pkg::REG_CTRL, d);
        check(d, {4'h0, lsb, inc, r, 1'b0});
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        forever #4 clock = ~clock;
    end
    initial begin
        repeat (80000) @(posedge clock);
        errors++;
        conclude();
    end
    initial begin
        logic [7:0] d;
        for (int i = 0; i < 128; i++) mem[i] = i[7:0] ^ 8'ha5;
        repeat (3) @(posedge clock);
        rst_n <= 1;
        rd(aih_pkg::REG_COUNT, d);
        check(d, 8'h01);
        rd(aih_pkg::REG_INDEX, d);
        check(d, 8'h00);
        rd(aih_pkg::REG_STATUS, d);
        check(d, 8'h00);
        wr(8'h3c, 8'hff);
        rd(8'h3c, d);
        check(d, 8'h00);
        check(mode_sel_pin, 1'b1);
        $display("test reset done");
        for (int k = 0; k < 6; k++) begin
            stretch <= SK[k];
            if (!RK[k]) idx = int'(lfsr() & 8'h7f);
            run(RK[k], IK[k], SK[k], nk[k]);
            $display("test %0d done", k);
        end
        nack_addr <= 1;
        wr(aih_pkg::REG_COUNT, 8'h01);
        wr(aih_pkg::REG_CTRL, 8'h01);
        wait_st(aih_pkg::STAT_DONE, 1'b1);
        rd(aih_pkg::REG_STATUS, d);
        check(d, 8'h18);
        wr(aih_pkg::REG_STATUS, 8'h18);
        rd(aih_pkg::REG_STATUS, d);
        check(d, 8'h00);
        nack_addr <= 0;
        $display("test nack done");
        for (int i = 0; i < 128; i++) check(u_sensor.mem[i], mem[i]);
        conclude();
    end
endmodule
